// File: logic/fcl_pkg.sv
// package: register map, fields, command codes for command launch control
package fcl_pkg;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] ADDR_CLKDIV  = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_INDEX   = 8'h08;
   localparam logic [7:0] ADDR_COBJ    = 8'h0C;
   localparam logic [7:0] ADDR_VERSION = 8'h10;
   localparam logic [7:0] ADDR_DONE    = 8'h14;
   // ************************************************************
   // fields and values
   // ************************************************************
   localparam int          DIV_W        = 7;
   localparam int          LOADED_BIT   = 7;
   localparam int          COMMAND_COMPLETE_FLAG_BIT     = 7;
   localparam int          ACCESS_ERROR_FLAG_BIT   = 5;
   localparam int          PROTECTION_VIOLATION_FLAG_BIT   = 4;
   localparam int          IDX_W        = 3;
   localparam int          COBJ_WORDS   = 6;
   localparam logic [2:0]  IDX_CMD      = 3'h0;
   localparam logic [15:0] IFR_VER_ADDR = 16'h40B6;
   // version value is arbitrary within the legal range
   localparam logic [3:0]  VERSION_NUM  = 4'h1;
   localparam logic [3:0]  VER_NONE_LO  = 4'h0;
   localparam logic [3:0]  VER_NONE_HI  = 4'hF;
   localparam logic [11:0] VER_RSVD     = 12'h000;
   localparam logic [15:0] COBJ_ZERO    = 16'h0000;
   localparam logic [31:0] RD_ZERO      = 32'h00000000;
   // ************************************************************
   // command codes
   // ************************************************************
   localparam logic [7:0] CMD_EVA   = 8'h01;
   localparam logic [7:0] CMD_EVB   = 8'h02;
   localparam logic [7:0] CMD_EVPS  = 8'h03;
   localparam logic [7:0] CMD_RDO   = 8'h04;
   localparam logic [7:0] CMD_PGMP  = 8'h06;
   localparam logic [7:0] CMD_PGMO  = 8'h07;
   localparam logic [7:0] CMD_ERA   = 8'h08;
   localparam logic [7:0] CMD_ERB   = 8'h09;
   localparam logic [7:0] CMD_ERPS  = 8'h0A;
   localparam logic [7:0] CMD_UNSEC = 8'h0B;
   localparam logic [7:0] CMD_BDKEY = 8'h0C;
   localparam logic [7:0] CMD_UMRG  = 8'h0D;
   localparam logic [7:0] CMD_FMRG  = 8'h0E;
   localparam logic [7:0] CMD_EVES  = 8'h10;
   localparam logic [7:0] CMD_PGME  = 8'h11;
   localparam logic [7:0] CMD_ERES  = 8'h12;
   typedef struct packed {
      logic [7:0] code;
      logic       special;
      logic       secure;
   } fcl_cmd_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_DONE = 3'b100
   } fcl_state_type;
endpackage

// File: logic/fcl_top.sv
// command launch, validation and register slave for flash controller
`timescale 1ns/1ns
module fcl_top (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // mode inputs
   input  wire logic        special_mode_i,
   input  wire logic        secure_i,
   input  wire logic        nvm_resource_select_i,
   // information row read port
   input  wire logic        ifr_rd_i,
   input  wire logic [15:0] ifr_addr_i,
   output logic      [15:0] ifr_rdata_o,
   // memory controller side
   input  wire logic        ctrl_done_i,
   input  wire logic        ctrl_prot_viol_i,
   output logic             launch_o,
   output logic      [95:0] launch_params_o,
   output logic      [6:0]  program_time_base_div_o
);
   // ************************************************************
   // functions
   // ************************************************************
   // command permission table by mode and security
   function automatic logic cmd_allowed(input fcl_pkg::fcl_cmd_type c);
      logic ss_sec;
      ss_sec = c.special & c.secure;
      case (c.code)
         fcl_pkg::CMD_EVA, fcl_pkg::CMD_EVB:
            cmd_allowed = 1'b1;
         fcl_pkg::CMD_EVPS, fcl_pkg::CMD_RDO, fcl_pkg::CMD_PGMP,
         fcl_pkg::CMD_PGMO, fcl_pkg::CMD_ERB, fcl_pkg::CMD_ERPS,
         fcl_pkg::CMD_UMRG, fcl_pkg::CMD_EVES, fcl_pkg::CMD_PGME,
         fcl_pkg::CMD_ERES:
            cmd_allowed = ~ss_sec;
         fcl_pkg::CMD_ERA, fcl_pkg::CMD_UNSEC:
            cmd_allowed = c.special;
         fcl_pkg::CMD_BDKEY:
            cmd_allowed = ~c.special;
         fcl_pkg::CMD_FMRG:
            cmd_allowed = c.special & ~c.secure;
         default:
            cmd_allowed = 1'b0;
      endcase
   endfunction
   // commands that program or erase and need the divider
   function automatic logic cmd_pgm_erase(input logic [7:0] code);
      case (code)
         fcl_pkg::CMD_PGMP, fcl_pkg::CMD_PGMO, fcl_pkg::CMD_ERA,
         fcl_pkg::CMD_ERB, fcl_pkg::CMD_ERPS, fcl_pkg::CMD_UNSEC,
         fcl_pkg::CMD_PGME, fcl_pkg::CMD_ERES:
            cmd_pgm_erase = 1'b1;
         default:
            cmd_pgm_erase = 1'b0;
      endcase
   endfunction
   // ************************************************************
   // state
   // ************************************************************
   logic [6:0]              div_r;
   logic                    loaded_r;
   logic                    command_complete_flag_r;
   logic                    access_error_flag_r;
   logic                    protection_violation_flag_r;
   logic [2:0]              idx_r;
   logic [15:0]             cobj_r [fcl_pkg::COBJ_WORDS];
   fcl_pkg::fcl_state_type  state_r;
   logic                    wr_en;
   logic                    rd_en;
   logic                    launch_req;
   logic                    bad_cmd;
   fcl_pkg::fcl_cmd_type    cmd;
   assign wr_en = psel_i & penable_i & pwrite_i & pready_o;
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;
   assign cmd.code    = cobj_r[fcl_pkg::IDX_CMD][15:8];
   assign cmd.special = special_mode_i;
   assign cmd.secure  = secure_i;
   // write-one to completion flag while idle launches
   assign launch_req = wr_en & (paddr_i == fcl_pkg::ADDR_STATUS)
                     & pwdata_i[fcl_pkg::COMMAND_COMPLETE_FLAG_BIT] & command_complete_flag_r;
   assign bad_cmd = ~cmd_allowed(cmd)
                  | (cmd_pgm_erase(cmd.code) & ~loaded_r);
   // ************************************************************
   // apb handshake: no wait states, ready registered from the setup phase
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= psel_i & ~penable_i;
      end
   end
   // ************************************************************
   // divider register
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         div_r    <= 7'h00;
         loaded_r <= 1'b0;
      end else if (wr_en && paddr_i == fcl_pkg::ADDR_CLKDIV) begin
         div_r    <= pwdata_i[fcl_pkg::DIV_W-1:0];
         loaded_r <= 1'b1;
      end
   end
   // ************************************************************
   // index and command array
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         idx_r <= 3'h0;
      end else if (wr_en && paddr_i == fcl_pkg::ADDR_INDEX) begin
         idx_r <= pwdata_i[fcl_pkg::IDX_W-1:0];
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < fcl_pkg::COBJ_WORDS; i++) begin
            cobj_r[i] <= fcl_pkg::COBJ_ZERO;
         end
      end else if (wr_en && paddr_i == fcl_pkg::ADDR_COBJ && command_complete_flag_r
                   && idx_r < 3'(fcl_pkg::COBJ_WORDS)) begin
         cobj_r[idx_r] <= pwdata_i[15:0];
      end
   end
   // ************************************************************
   // launch sequencer
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_r  <= fcl_pkg::ST_IDLE;
         command_complete_flag_r   <= 1'b1;
         launch_o <= 1'b0;
      end else begin
         launch_o <= 1'b0;
         case (state_r)
            fcl_pkg::ST_IDLE: begin
               if (launch_req) begin
                  command_complete_flag_r <= 1'b0;
                  if (bad_cmd) begin
                     state_r <= fcl_pkg::ST_DONE;
                  end else begin
                     launch_o <= 1'b1;
                     state_r  <= fcl_pkg::ST_RUN;
                  end
               end
            end
            fcl_pkg::ST_RUN: begin
               if (ctrl_done_i) begin
                  state_r <= fcl_pkg::ST_DONE;
               end
            end
            fcl_pkg::ST_DONE: begin
               command_complete_flag_r  <= 1'b1;
               state_r <= fcl_pkg::ST_IDLE;
            end
            default: begin
               state_r <= fcl_pkg::ST_IDLE;
               command_complete_flag_r  <= 1'b1;
            end
         endcase
      end
   end
   // ************************************************************
   // error flags: set wins over write-one clear
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         access_error_flag_r <= 1'b0;
         protection_violation_flag_r <= 1'b0;
      end else begin
         if (launch_req && bad_cmd) begin
            access_error_flag_r <= 1'b1;
         end else if (wr_en && paddr_i == fcl_pkg::ADDR_STATUS
                      && pwdata_i[fcl_pkg::ACCESS_ERROR_FLAG_BIT]) begin
            access_error_flag_r <= 1'b0;
         end
         if (ctrl_prot_viol_i) begin
            protection_violation_flag_r <= 1'b1;
         end else if (wr_en && paddr_i == fcl_pkg::ADDR_STATUS
                      && pwdata_i[fcl_pkg::PROTECTION_VIOLATION_FLAG_BIT]) begin
            protection_violation_flag_r <= 1'b0;
         end
      end
   end
   // ************************************************************
   // outputs to controller, apb read data
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         launch_params_o         <= 96'h0;
         program_time_base_div_o <= 7'h00;
         prdata_o                <= fcl_pkg::RD_ZERO;
         pslverr_o               <= 1'b0;
      end else begin
         program_time_base_div_o <= div_r;
         if (launch_req) begin
            launch_params_o <= {cobj_r[5], cobj_r[4], cobj_r[3],
                                cobj_r[2], cobj_r[1], cobj_r[0]};
         end
         pslverr_o <= 1'b0;
         prdata_o  <= fcl_pkg::RD_ZERO;
         if (rd_en) begin
            case (paddr_i)
               fcl_pkg::ADDR_CLKDIV:
                  prdata_o <= {24'h0, loaded_r, div_r};
               fcl_pkg::ADDR_STATUS:
                  prdata_o <= {24'h0, command_complete_flag_r, 1'b0, access_error_flag_r, protection_violation_flag_r,
                               4'h0};
               fcl_pkg::ADDR_INDEX:
                  prdata_o <= {29'h0, idx_r};
               fcl_pkg::ADDR_COBJ:
                  prdata_o <= (idx_r < 3'(fcl_pkg::COBJ_WORDS)) ?
                              {16'h0, cobj_r[idx_r]} :
                              fcl_pkg::RD_ZERO;
               fcl_pkg::ADDR_VERSION:
                  prdata_o <= {28'h0, fcl_pkg::VERSION_NUM};
               default:
                  pslverr_o <= 1'b1;
            endcase
         end
      end
   end
   // ************************************************************
   // information row version word
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ifr_rdata_o <= fcl_pkg::COBJ_ZERO;
      end else if (ifr_rd_i && nvm_resource_select_i
                   && ifr_addr_i == fcl_pkg::IFR_VER_ADDR) begin
         ifr_rdata_o <= {fcl_pkg::VER_RSVD,
                         fcl_pkg::VERSION_NUM};
      end else begin
         ifr_rdata_o <= fcl_pkg::COBJ_ZERO;
      end
   end
   // ************************************************************
   // assertions
   // ************************************************************
   property p_launch_clears;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      launch_req |=> !command_complete_flag_r;
   endproperty
   a_launch_clears: assert property (p_launch_clears)
      else $error("completion flag not cleared on launch");
   property p_bad_sets_err;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      launch_req && bad_cmd |=> access_error_flag_r && !launch_o ##1 command_complete_flag_r;
   endproperty
   a_bad_sets_err: assert property (p_bad_sets_err)
      else $error("refused command mishandled");
   property p_nodiv;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      launch_req && !loaded_r && cmd_pgm_erase(cmd.code) |=> access_error_flag_r;
   endproperty
   a_nodiv: assert property (p_nodiv)
      else $error("missing divider not flagged");
   property p_div_loaded;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      wr_en && paddr_i == fcl_pkg::ADDR_CLKDIV |=> loaded_r;
   endproperty
   a_div_loaded: assert property (p_div_loaded)
      else $error("divider loaded flag not set");
   property p_busy_lock;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !command_complete_flag_r |=> $stable(cobj_r[0]);
   endproperty
   a_busy_lock: assert property (p_busy_lock)
      else $error("command array changed while busy");
   property p_run_busy;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == fcl_pkg::ST_RUN |-> !command_complete_flag_r;
   endproperty
   a_run_busy: assert property (p_run_busy)
      else $error("completion flag set during execution");
   property p_done_sets;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == fcl_pkg::ST_RUN && ctrl_done_i |=> ##1 command_complete_flag_r;
   endproperty
   a_done_sets: assert property (p_done_sets)
      else $error("completion flag not restored");
   property p_ifr_gate;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !nvm_resource_select_i |=> ifr_rdata_o == fcl_pkg::COBJ_ZERO;
   endproperty
   a_ifr_gate: assert property (p_ifr_gate)
      else $error("information row read without select");
   property p_fmrg;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      launch_req && cmd.code == fcl_pkg::CMD_FMRG && cmd.secure
      |=> !launch_o;
   endproperty
   a_fmrg: assert property (p_fmrg)
      else $error("field margin launched while secured");
   c_launch: cover property (@(posedge core_clk_i) launch_o);
   c_refused: cover property (@(posedge core_clk_i)
      launch_req && bad_cmd);
   c_done: cover property (@(posedge core_clk_i)
      state_r == fcl_pkg::ST_RUN && ctrl_done_i);
endmodule

// File: tb/tb_fcl_top.sv
// self-checking testbench for the command launch control block
`timescale 1ns/1ns
module tb_fcl_top;
   // ************************************************************
   // signals
   // ************************************************************
   logic        core_clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        special;
   logic        secure;
   logic        nvm_sel;
   logic        ifr_rd;
   logic [15:0] ifr_addr;
   logic [15:0] ifr_rdata;
   logic        done;
   logic        pviol;
   logic        launch;
   logic [95:0] params;
   logic [6:0]  div;
   logic [31:0] rd;
   logic        err;
   int          fails;
   int          samples_checked;
   int          cycles;
   int          launch_cnt;
   fcl_top uut (
      .core_clk_i              (core_clk),
      .rst_n_i                 (rst_n),
      .psel_i                  (psel),
      .penable_i               (penable),
      .pwrite_i                (pwrite),
      .paddr_i                 (paddr),
      .pwdata_i                (pwdata),
      .prdata_o                (prdata),
      .pready_o                (pready),
      .pslverr_o               (pslverr),
      .special_mode_i          (special),
      .secure_i                (secure),
      .nvm_resource_select_i   (nvm_sel),
      .ifr_rd_i                (ifr_rd),
      .ifr_addr_i              (ifr_addr),
      .ifr_rdata_o             (ifr_rdata),
      .ctrl_done_i             (done),
      .ctrl_prot_viol_i        (pviol),
      .launch_o                (launch),
      .launch_params_o         (params),
      .program_time_base_div_o (div)
   );
   // ************************************************************
   // clock, timeout, launch monitor
   // ************************************************************
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         fails = fails + 1;
         close_out();
      end
   end
   always @(negedge core_clk) begin
      if (launch === 1'b1) launch_cnt = launch_cnt + 1;
   end
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic close_out;
      $display("counts: checked %0d failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic finish_cmd;
      int k;
      k = 0;
      @(posedge core_clk);
      done <= 1'b1;
      @(posedge core_clk);
      done <= 1'b0;
      do begin
         apb(1'b0, fcl_pkg::ADDR_STATUS, 32'h0);
         k++;
      end while (rd[7] !== 1'b1 && k < 10);
   endtask
   function automatic logic ok_exp(input logic [7:0] c, input logic sp,
                                   input logic se);
      case (c)
         8'h01, 8'h02: return 1'b1;
         8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0D, 8'h10, 8'h11,
         8'h12: return !(sp && se);
         8'h08, 8'h0B: return sp;
         8'h0C: return !sp;
         8'h0E: return sp && !se;
         default: return 1'b0;
      endcase
   endfunction
   task automatic run_cmd(input logic [7:0] c, input logic sp,
                          input logic se, input logic ok);
      int n0;
      special <= sp;
      secure <= se;
      apb(1'b1, fcl_pkg::ADDR_INDEX, 32'h0);
      apb(1'b1, fcl_pkg::ADDR_COBJ, {16'h0, c, 8'h00});
      n0 = launch_cnt;
      apb(1'b1, fcl_pkg::ADDR_STATUS, 32'h80);
      if (ok) finish_cmd();
      else apb(1'b0, fcl_pkg::ADDR_STATUS, 32'h0);
      chk("launch count", 32'(launch_cnt - n0), {31'h0, ok});
      chk("access error", {31'h0, rd[5]}, {31'h0, !ok});
      chk("complete flag", {31'h0, rd[7]}, 32'h1);
      if (rd[5] === 1'b1) apb(1'b1, fcl_pkg::ADDR_STATUS, 32'h20);
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset;
      apb(1'b0, fcl_pkg::ADDR_CLKDIV, 32'h0);
      chk("divider at reset", rd, 32'h0);
      apb(1'b0, fcl_pkg::ADDR_STATUS, 32'h0);
      chk("status at reset", rd, 32'h80);
      apb(1'b0, fcl_pkg::ADDR_VERSION, 32'h0);
      chk("version word", rd, 32'h1);
      apb(1'b0, 8'h3C, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      $display("test reset done");
   endtask
   task automatic t_nodiv;
      run_cmd(8'h06, 1'b0, 1'b0, 1'b0);
      run_cmd(8'h01, 1'b0, 1'b0, 1'b1);
      apb(1'b1, fcl_pkg::ADDR_CLKDIV, 32'h18);
      apb(1'b0, fcl_pkg::ADDR_CLKDIV, 32'h0);
      chk("divider loaded", rd, 32'h98);
      chk("divider out", {25'h0, div}, 32'h18);
      $display("test divider done");
   endtask
   task automatic t_modes;
      logic [7:0] codes [18];
      codes = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09,
                8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12,
                8'h05, 8'hFF};
      for (int m = 0; m < 4; m++) begin
         for (int i = 0; i < 18; i++) begin
            run_cmd(codes[i], m[1], m[0], ok_exp(codes[i], m[1], m[0]));
         end
      end
      $display("test modes done");
   endtask
   task automatic t_busy;
      int n0;
      special <= 1'b0;
      secure <= 1'b0;
      apb(1'b1, fcl_pkg::ADDR_INDEX, 32'h1);
      apb(1'b1, fcl_pkg::ADDR_COBJ, 32'h1234);
      apb(1'b1, fcl_pkg::ADDR_INDEX, 32'h0);
      apb(1'b1, fcl_pkg::ADDR_COBJ, 32'h0100);
      n0 = launch_cnt;
      apb(1'b1, fcl_pkg::ADDR_STATUS, 32'h80);
      apb(1'b0, fcl_pkg::ADDR_STATUS, 32'h0);
      chk("busy flag", {31'h0, rd[7]}, 32'h0);
      chk("params", params[31:0], 32'h12340100);
      apb(1'b1, fcl_pkg::ADDR_COBJ, 32'h5555);
      apb(1'b1, fcl_pkg::ADDR_STATUS, 32'h80);
      @(negedge core_clk);
      chk("relaunch", 32'(launch_cnt - n0), 32'h1);
      finish_cmd();
      apb(1'b0, fcl_pkg::ADDR_COBJ, 32'h0);
      chk("array kept", rd, 32'h0100);
      for (int i = 6; i < 8; i++) begin
         apb(1'b1, fcl_pkg::ADDR_INDEX, 32'(i));
         apb(1'b1, fcl_pkg::ADDR_COBJ, 32'hFFFF);
         apb(1'b0, fcl_pkg::ADDR_COBJ, 32'h0);
         chk("unused index", rd, 32'h0);
      end
      $display("test busy done");
   endtask
   task automatic ifr_chk(input logic sel, input logic [15:0] exp);
      @(posedge core_clk);
      nvm_sel <= sel;
      ifr_rd <= 1'b1;
      ifr_addr <= fcl_pkg::IFR_VER_ADDR;
      @(posedge core_clk);
      ifr_rd <= 1'b0;
      @(negedge core_clk);
      chk("ifr word", {16'h0, ifr_rdata}, {16'h0, exp});
   endtask
   task automatic t_misc;
      ifr_chk(1'b1, 16'h0001);
      ifr_chk(1'b0, 16'h0000);
      @(posedge core_clk);
      pviol <= 1'b1;
      @(posedge core_clk);
      pviol <= 1'b0;
      apb(1'b0, fcl_pkg::ADDR_STATUS, 32'h0);
      chk("violation set", rd, 32'h90);
      apb(1'b1, fcl_pkg::ADDR_STATUS, 32'h10);
      apb(1'b0, fcl_pkg::ADDR_STATUS, 32'h0);
      chk("violation clear", rd, 32'h80);
      $display("test ifr and violation done");
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {rst_n, psel, penable, pwrite, special, secure} = '0;
      {nvm_sel, ifr_rd, done, pviol} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ifr_addr = 16'h0;
      fails = 0;
      samples_checked = 0;
      cycles = 0;
      launch_cnt = 0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_nodiv();
      t_modes();
      t_busy();
      t_misc();
      close_out();
   end
endmodule
